// File: hdl/mic_detect.sv
`timescale 1ns/100ps
`include "mic_detect_params.svh"
module mic_detect #(
   parameter int HOOK_RUN = `HOOK_SAMPLES,
   parameter int DB_RUN = `DEBOUNCE_SAMPLES
) (
   input wire logic sys_clk, // 40 MHz clock
   input wire logic rst, // async reset, active high
   input wire logic sample_valid, // bias current sample strobe
   input wire logic presence_above, // current above presence threshold
   input wire logic hook_above, // current above hook threshold
   input wire logic [3:0] avs_address, // word address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   output logic irq, // level interrupt
   output logic detect_gpio // steady detection state
);
   initial begin
      if (HOOK_RUN < 1 || DB_RUN < 1) $error("mic_detect: bad run length");
   end
   mic_detect_pkg::ctl_s ctl, next_ctl;
   mic_detect_pkg::bus_state_e bst, next_bst;
   logic [1:0] status, next_status, mask, next_mask;
   logic [31:0] next_rdata;
   logic pres_state, hook_state, pres_prev, hook_prev;
   logic pres_evt, hook_evt;
   logic gpio_next;

   // presence path: debounce optional, one sample otherwise
   sample_filter #(.RUN(DB_RUN)) u_pres (
      .sys_clk(sys_clk), .rst(rst), .sample_valid(sample_valid),
      .sample_level(presence_above),
      .filt_en(ctl.pres_db),
      .steady(pres_state)
   );
   // hook path: always a run of HOOK_RUN samples; debounce asks for a
   // longer run of HOOK_RUN + DB_RUN. two filters run side by side, as
   // a chained stage would lose the sample that flips the first one.
   // limitation: switching debounce while the two disagree may give
   // a spurious event, so change it only while the hook is steady
   logic hook_run;
   logic hook_long;
   sample_filter #(.RUN(HOOK_RUN)) u_hook (
      .sys_clk(sys_clk), .rst(rst), .sample_valid(sample_valid),
      .sample_level(hook_above), .filt_en(1'b1),
      .steady(hook_run)
   );
   sample_filter #(.RUN(HOOK_RUN + DB_RUN)) u_hook_db (
      .sys_clk(sys_clk), .rst(rst), .sample_valid(sample_valid),
      .sample_level(hook_above), .filt_en(1'b1),
      .steady(hook_long)
   );
   assign hook_state = ctl.hook_db ? hook_long : hook_run;

   // event = filtered state changes to the opposite of the armed polarity: 0 waits for
   // insertion/press (high), 1 waits for removal/release (low)
   always_comb begin
      pres_evt = (pres_state != ctl.pres_pol) && (pres_state != pres_prev);
      hook_evt = (hook_state != ctl.hook_pol) && (hook_state != hook_prev);
   end

   always_comb begin
      next_ctl = ctl;
      next_mask = mask;
      next_status = status;
      next_bst = bst;
      next_rdata = avs_readdata;
      case (bst)
         mic_detect_pkg::BUS_IDLE: begin
            if (avs_write) begin
               next_bst = mic_detect_pkg::BUS_ACK;
            end else if (avs_read) begin
               if (avs_address == `ADDR_STATUS) begin
                  next_rdata = {30'h0, status};
               end else if (avs_address == `ADDR_MASK) begin
                  next_rdata = {30'h0, mask};
               end else if (avs_address == `ADDR_CONTROL) begin
                  next_rdata = {27'h0, ctl.gpio_sel, ctl.hook_db,
                                ctl.pres_db, ctl.hook_pol, ctl.pres_pol};
               end else if (avs_address == `ADDR_STATE) begin
                  next_rdata = {30'h0, hook_state, pres_state};
               end else begin
                  next_rdata = `UNMAPPED_DATA;
               end
               next_bst = mic_detect_pkg::BUS_ACK;
            end
         end
         // a write lands at the edge where waitrequest is seen low
         mic_detect_pkg::BUS_ACK: begin
            if (avs_write) begin
               if (avs_address == `ADDR_STATUS) begin
                  next_status = status & ~avs_writedata[1:0];
               end else if (avs_address == `ADDR_MASK) begin
                  next_mask = avs_writedata[1:0];
               end else if (avs_address == `ADDR_CONTROL) begin
                  next_ctl.pres_pol = avs_writedata[`CTL_PRES_POL];
                  next_ctl.hook_pol = avs_writedata[`CTL_HOOK_POL];
                  next_ctl.pres_db = avs_writedata[`CTL_PRES_DB];
                  next_ctl.hook_db = avs_writedata[`CTL_HOOK_DB];
                  next_ctl.gpio_sel = avs_writedata[`CTL_GPIO_SEL];
               end
            end
            next_bst = mic_detect_pkg::BUS_HOLD;
         end
         mic_detect_pkg::BUS_HOLD: next_bst = mic_detect_pkg::BUS_IDLE;
         default: next_bst = mic_detect_pkg::BUS_IDLE;
      endcase
      // set wins over a same-cycle clear
      if (pres_evt) next_status[`BIT_PRESENCE] = 1'b1;
      if (hook_evt) next_status[`BIT_HOOK] = 1'b1;
      gpio_next = ctl.gpio_sel ? hook_state : pres_state;
   end

   // answer one cycle after the request is seen; the hold state keeps
   // a released request from being taken twice
   assign avs_waitrequest = (bst != mic_detect_pkg::BUS_ACK);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctl <= '0;
         mask <= 2'h0;
         status <= 2'h0;
         bst <= mic_detect_pkg::BUS_IDLE;
         avs_readdata <= 32'h0;
         pres_prev <= 1'b0;
         hook_prev <= 1'b0;
         irq <= 1'b0;
         detect_gpio <= 1'b0;
      end else begin
         ctl <= next_ctl;
         mask <= next_mask;
         status <= next_status;
         bst <= next_bst;
         avs_readdata <= next_rdata;
         pres_prev <= pres_state;
         hook_prev <= hook_state;
         irq <= |(next_status & next_mask);
         detect_gpio <= gpio_next;
      end
   end

   a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
      status[`BIT_HOOK] && !(bst == mic_detect_pkg::BUS_ACK && avs_write
      && avs_address == `ADDR_STATUS) |=> status[`BIT_HOOK])
      else $error("hook flag dropped without clear");
   a_hook_event: assert property (@(posedge sys_clk) disable iff (rst)
      hook_evt |=> status[`BIT_HOOK])
      else $error("hook event not flagged");
   a_pres_event: assert property (@(posedge sys_clk) disable iff (rst)
      pres_evt |=> status[`BIT_PRESENCE])
      else $error("presence event not flagged");
   a_gpio_follows: assert property (@(posedge sys_clk) disable iff (rst)
      !ctl.gpio_sel && $stable(ctl) |=> detect_gpio == $past(pres_state))
      else $error("gpio not tracking presence");
   a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
      irq == |(status & mask))
      else $error("irq mismatch");
   a_wait_ack: assert property (@(posedge sys_clk) disable iff (rst)
      bst == mic_detect_pkg::BUS_IDLE && (avs_read || avs_write)
      |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer timing wrong");
   a_hook_rise: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(hook_run) |-> $past(hook_above))
      else $error("hook rose without samples");
   a_hook_fall: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(hook_run) |-> !$past(hook_above))
      else $error("hook fell without samples");
endmodule

// File: hdl/mic_detect_params.svh
`ifndef MIC_DETECT_PARAMS_SVH
`define MIC_DETECT_PARAMS_SVH
`define ADDR_STATUS 4'h0
`define ADDR_MASK 4'h1
`define ADDR_CONTROL 4'h2
`define ADDR_STATE 4'h3
`define BIT_PRESENCE 0
`define BIT_HOOK 1
`define CTL_PRES_POL 0
`define CTL_HOOK_POL 1
`define CTL_PRES_DB 2
`define CTL_HOOK_DB 3
`define CTL_GPIO_SEL 4
`define HOOK_SAMPLES 10
`define DEBOUNCE_SAMPLES 4
`define UNMAPPED_DATA 32'hdeadbeef
`endif

// File: hdl/mic_detect_pkg.sv
package mic_detect_pkg;
   typedef struct packed {
      logic pres_pol;
      logic hook_pol;
      logic pres_db;
      logic hook_db;
      logic gpio_sel;
   } ctl_s;
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_ACK = 3'b010,
      BUS_HOLD = 3'b100
   } bus_state_e;
endpackage

// File: hdl/sample_filter.sv
`timescale 1ns/100ps
`include "mic_detect_params.svh"
// counts consecutive samples that differ from the steady level; with filt_en set, a level change is accepted
// only once the count reaches the required run length
module sample_filter #(
   parameter int RUN = 10
) (
   input wire logic sys_clk, // clock
   input wire logic rst, // async reset
   input wire logic sample_valid, // new sample strobe
   input wire logic sample_level, // raw comparator level
   input wire logic filt_en, // 1: require RUN samples
   output logic steady // filtered level
);
   localparam int CW = $clog2(RUN + 1);
   initial begin
      if (RUN < 1) $error("sample_filter: RUN must be at least 1");
   end
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic next_steady;
   always_comb begin
      next_cnt = cnt;
      next_steady = steady;
      if (sample_valid) begin
         if (sample_level == steady) begin
            next_cnt = '0;
         end else if (!filt_en || cnt == CW'(RUN - 1)) begin
            next_steady = sample_level;
            next_cnt = '0;
         end else begin
            next_cnt = cnt + CW'(1);
         end
      end
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
         steady <= 1'b0;
      end else begin
         cnt <= next_cnt;
         steady <= next_steady;
      end
   end
endmodule

// File: verification/bias_source.sv
`timescale 1ns/100ps
// sensor side: a sample every other cycle while enabled; the levels
// invert between strobes so nothing leans on stale comparator data
module bias_source (
   input wire logic sys_clk, // clock
   input wire logic rst, // async reset
   input wire logic en, // emit samples
   input wire logic pres_lvl, // presence comparator level
   input wire logic hook_lvl, // hook comparator level
   output logic sample_valid, // sample strobe
   output logic presence_above, // presence level
   output logic hook_above // hook level
);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) sample_valid <= 1'b0;
      else sample_valid <= en & ~sample_valid;
   end
   assign presence_above = sample_valid ? pres_lvl : ~pres_lvl;
   assign hook_above = sample_valid ? hook_lvl : ~hook_lvl;
endmodule

// File: verification/tb_top.sv
`timescale 1ns/100ps
`include "mic_detect_params.svh"
module tb_top;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b0;
   logic pres_lvl = 1'b0;
   logic hook_lvl = 1'b0;
   logic sample_valid, presence_above, hook_above;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, irq, detect_gpio;
   int bad_count = 0;
   int total_checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   bias_source bias_source_i (.sys_clk, .rst, .en, .pres_lvl, .hook_lvl,
      .sample_valid, .presence_above, .hook_above);
   mic_detect mic_detect_i (.sys_clk, .rst, .sample_valid,
      .presence_above, .hook_above, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .detect_gpio);
   task summarize;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // one avalon transfer held until waitrequest is seen low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         bad_count++;
         summarize();
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   // n samples, then a pause so flag and irq can land before the read
   task step(input int n, input logic [3:0] a, input logic [31:0] exp);
      int k;
      k = 0;
      if (n > 0) en <= 1'b1;
      for (int c = 0; c < 4 * n + 4 && k < n; c++) begin
         @(posedge sys_clk);
         if (sample_valid === 1'b1) k++;
      end
      if (n > 0) en <= 1'b0;
      if (k < n) begin
         bad_count++;
         summarize();
      end
      repeat (3) @(posedge sys_clk);
      bus(1'b0, a, 32'h0);
      check(q, exp);
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      check(32'(avs_waitrequest), 32'h1);
      bus(1'b0, `ADDR_STATUS, 32'h0);
      check(q, 32'h0);
      bus(1'b0, 4'h9, 32'h0);
      check(q, `UNMAPPED_DATA);
      bus(1'b1, `ADDR_MASK, 32'h3);
      pres_lvl <= 1'b1;
      step(1, `ADDR_STATUS, 32'h1);
      check(32'(irq), 32'h1);
      check(32'(detect_gpio), 32'h1);
      step(0, `ADDR_STATUS, 32'h1);
      bus(1'b1, `ADDR_MASK, 32'h0);
      check(32'(irq), 32'h0);
      bus(1'b1, `ADDR_MASK, 32'h3);
      bus(1'b1, `ADDR_CONTROL, 32'h1);
      bus(1'b1, `ADDR_STATUS, 32'h1);
      step(0, `ADDR_STATUS, 32'h0);
      check(32'(irq), 32'h0);
      hook_lvl <= 1'b1;
      step(`HOOK_SAMPLES - 1, `ADDR_STATUS, 32'h0);
      step(1, `ADDR_STATUS, 32'h2);
      bus(1'b1, `ADDR_CONTROL, 32'h13);
      bus(1'b1, `ADDR_STATUS, 32'h2);
      hook_lvl <= 1'b0;
      step(`HOOK_SAMPLES - 1, `ADDR_STATUS, 32'h0);
      check(32'(detect_gpio), 32'h1);
      step(1, `ADDR_STATUS, 32'h2);
      check(32'(detect_gpio), 32'h0);
      bus(1'b1, `ADDR_CONTROL, 32'h5);
      bus(1'b1, `ADDR_STATUS, 32'h2);
      pres_lvl <= 1'b0;
      step(`DEBOUNCE_SAMPLES - 1, `ADDR_STATUS, 32'h0);
      step(1, `ADDR_STATUS, 32'h1);
      bus(1'b1, `ADDR_CONTROL, 32'h8);
      bus(1'b1, `ADDR_STATUS, 32'h1);
      hook_lvl <= 1'b1;
      step(`HOOK_SAMPLES + `DEBOUNCE_SAMPLES - 1, `ADDR_STATUS,
         32'h0);
      step(1, `ADDR_STATUS, 32'h2);
      bus(1'b1, `ADDR_STATE, 32'h1);
      step(0, `ADDR_STATE, 32'h2);
      summarize();
   end
endmodule
